// ---- shared/lbl_defs.svh ----
/*
  Offsets, field positions, reset values and codes of the line-by-line
  colour select block. Assumes an 8-bit register port with 4-bit index.
*/
// Function
// - Bit 0 selects line sequential mode
// - Line mode forces mono one, channel red
// - Line mode disables green and blue gain
// - Select zero: pin clamps, internal colour choice
// - Select one: pin pulses step colour cycle
// - Auto-cycling ignores pin as clamp request
// - Bit 3 clamps only in line auto-cycle
// - Bit 2 overrides input mux in line mode
// - Bits 5:4 pick internal colour code
// - Bits 7:6 pick forced input mux colour
// - Auto-cycle reset write returns to red
// - Channel pick codes red, green, blue
`ifndef LBL_DEFS_SVH
`define LBL_DEFS_SVH

// ---------------------------------------------------------------
// Register indexes
// ---------------------------------------------------------------
`define LBL_ADDR_CTRL     4'h4
`define LBL_ADDR_MONO     4'h3
`define LBL_ADDR_ACYC_RST 4'h8
`define LBL_ADDR_STATUS   4'h9

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LBL_BIT_LINE      0
`define LBL_BIT_PINSEL    1
`define LBL_BIT_OVR_EN    2
`define LBL_BIT_CLAMP_EN  3
`define LBL_INTC_LSB      4
`define LBL_OVRC_LSB      6
`define LBL_BIT_MONO      2
`define LBL_CHAN_LSB      6

// ---------------------------------------------------------------
// Reset values and colour codes
// ---------------------------------------------------------------
`define LBL_CTRL_RESET    8'h00
`define LBL_MONO_RESET    8'h00
`define LBL_RED           2'h0
`define LBL_GREEN         2'h1
`define LBL_BLUE          2'h2

`endif

// ---- shared/lbl_pkg.sv ----
/*
  Types of the line-by-line colour select block.
  Assumes lbl_defs.svh supplies the numeric constants.
*/
package lbl_pkg;

    // Colour codes of the auto-cycle counter state only
    typedef enum logic [1:0] {
        LBL_COL_RED   = 2'h0,
        LBL_COL_GREEN = 2'h1,
        LBL_COL_BLUE  = 2'h3
    } lbl_colour_t;

    // Auto-cycle counter state, Gray coded along red, green, blue
    typedef struct packed {
        lbl_colour_t colour;
        logic        pin_prev;
    } lbl_cyc_state_t;

    // Register state of the top
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mono;
        logic [7:0] rdata;
    } lbl_state_t;

endpackage : lbl_pkg

// ---- rtl/lbl_cycle.sv ----
/*
  Colour auto-cycle counter: steps red, green, blue on rising edges
  of the shared pin. Assumes the pin is synchronous to mclk.
*/
`include "lbl_defs.svh"

module lbl_cycle (
    input  wire logic       mclk,     // 100 MHz clock
    input  wire logic       reset,    // Synchronous, active high
    input  wire logic       step_en,  // Line mode with auto-cycle
    input  wire logic       pin,      // Shared clamp or cycle pin
    input  wire logic       restart,  // Return to red
    output logic      [1:0] colour    // Current colour code
);
    lbl_pkg::lbl_cyc_state_t st;
    lbl_pkg::lbl_cyc_state_t next_st;
    logic                    pulse;

    // Rising edge of the pin marks a step request
    assign pulse = pin && !st.pin_prev;

    // Next counter state
    always_comb
    begin
        next_st = st;
        next_st.pin_prev = pin;
        if (restart)
        begin
            next_st.colour = lbl_pkg::LBL_COL_RED;
        end
        else if (step_en && pulse)
        begin
            case (st.colour)
                lbl_pkg::LBL_COL_RED:
                    next_st.colour = lbl_pkg::LBL_COL_GREEN;
                lbl_pkg::LBL_COL_GREEN: next_st.colour = lbl_pkg::LBL_COL_BLUE;
                default:                next_st.colour = lbl_pkg::LBL_COL_RED;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st.colour   <= lbl_pkg::LBL_COL_RED;
            st.pin_prev <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Convert Gray state to the register colour code
    always_comb
    begin
        case (st.colour)
            lbl_pkg::LBL_COL_GREEN: colour = `LBL_GREEN;
            lbl_pkg::LBL_COL_BLUE:  colour = `LBL_BLUE;
            default:                colour = `LBL_RED;
        endcase
    end

endmodule : lbl_cycle

// ---- rtl/lbl_top.sv ----
/*
  Line sequence control register and the colour, clamp and gain
  selection it drives. Assumes a plain register port: one-cycle
  strobes, read data in the cycle after the read strobe, and a
  shared pin that is synchronous to mclk.
*/
`include "lbl_defs.svh"

module lbl_top #(
    parameter int ADDR_W = 4              // Register index width
) (
    input  wire logic              mclk,        // 100 MHz clock
    input  wire logic              reset,       // Sync, active high
    input  wire logic [ADDR_W-1:0] addr,        // Register index
    input  wire logic        [7:0] wdata,       // Write data
    input  wire logic              wr,          // Write strobe
    input  wire logic              rd,          // Read strobe
    output logic             [7:0] rdata,       // Read data, next cycle
    input  wire logic              clamp_or_cycle_pin, // Shared pin
    output logic                   mono_effective,     // Single channel
    output logic             [1:0] channel_effective,  // Mono channel
    output logic             [1:0] input_mux_sel,      // Input colour
    output logic             [1:0] gain_offset_sel,    // Gain colour
    output logic                   clamp_active,       // Clamp request
    output logic                   red_gain_en,        // Red gain path
    output logic                   green_gain_en,      // Green gain
    output logic                   blue_gain_en        // Blue gain
);

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    if (ADDR_W < 4)
    begin : g_bad_addr
        $error("ADDR_W must be at least 4");
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // Reserved code 11 is served as red
    function automatic logic [1:0] colour_of(input logic [1:0] code);
        colour_of = (code == 2'h3) ? `LBL_RED : code;
    endfunction : colour_of

    // Index match against a 4-bit constant
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0]        idx);
        hit = (a == ADDR_W'(idx));
    endfunction : hit

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    lbl_pkg::lbl_state_t st;
    lbl_pkg::lbl_state_t next_st;

    logic       line_mode;
    logic       pin_select;
    logic       ovr_en;
    logic       int_clamp;
    logic [1:0] int_colour;
    logic [1:0] ovr_colour;
    logic       prog_mono;
    logic [1:0] prog_chan;
    logic       auto_cycle;
    logic [1:0] cyc_colour;
    logic       cyc_restart;
    logic [7:0] status;

    // Control field split
    assign line_mode  = st.ctrl[`LBL_BIT_LINE];
    assign pin_select = st.ctrl[`LBL_BIT_PINSEL];
    assign ovr_en     = st.ctrl[`LBL_BIT_OVR_EN];
    assign int_clamp  = st.ctrl[`LBL_BIT_CLAMP_EN];
    assign int_colour = st.ctrl[`LBL_INTC_LSB +: 2];
    assign ovr_colour = st.ctrl[`LBL_OVRC_LSB +: 2];
    assign prog_mono  = st.mono[`LBL_BIT_MONO];
    assign prog_chan  = st.mono[`LBL_CHAN_LSB +: 2];

    // Pin select bit only counts in line mode
    assign auto_cycle  = line_mode && pin_select;
    assign cyc_restart = wr && hit(addr, `LBL_ADDR_ACYC_RST);

    // ---------------------------------------------------------------
    // Auto-cycle counter
    // ---------------------------------------------------------------
    lbl_cycle u_cycle (
        .mclk    (mclk),
        .reset   (reset),
        .step_en (auto_cycle),
        .pin     (clamp_or_cycle_pin),
        .restart (cyc_restart),
        .colour  (cyc_colour)
    );

    // ---------------------------------------------------------------
    // Selection logic
    // ---------------------------------------------------------------

    // Mono forcing in line mode
    always_comb
    begin
        if (line_mode)
        begin
            mono_effective    = 1'b1;
            channel_effective = `LBL_RED;
        end
        else
        begin
            mono_effective    = prog_mono;
            channel_effective = colour_of(prog_chan);
        end
    end

    // Colour and clamp source
    always_comb
    begin
        if (!line_mode)
        begin
            gain_offset_sel = colour_of(prog_chan);
            input_mux_sel   = colour_of(prog_chan);
            clamp_active    = clamp_or_cycle_pin;
        end
        else if (auto_cycle)
        begin
            gain_offset_sel = cyc_colour;
            input_mux_sel   = cyc_colour;
            clamp_active    = int_clamp;
        end
        else
        begin
            gain_offset_sel = colour_of(int_colour);
            input_mux_sel   = colour_of(int_colour);
            clamp_active    = clamp_or_cycle_pin;
        end
        if (line_mode && ovr_en)
        begin
            input_mux_sel = colour_of(ovr_colour);
        end
    end

    // Gain path enables
    assign red_gain_en   = 1'b1;
    assign green_gain_en = !line_mode;
    assign blue_gain_en  = !line_mode;

    // Status word of effective selections
    assign status = {clamp_active, gain_offset_sel, input_mux_sel,
                     channel_effective, mono_effective};

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------

    // Next register state
    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (wr && hit(addr, `LBL_ADDR_CTRL))
        begin
            next_st.ctrl = wdata;
        end
        if (wr && hit(addr, `LBL_ADDR_MONO))
        begin
            next_st.mono = wdata;
        end
        if (rd)
        begin
            if (hit(addr, `LBL_ADDR_CTRL))
            begin
                next_st.rdata = st.ctrl;
            end
            else if (hit(addr, `LBL_ADDR_MONO))
            begin
                next_st.rdata = st.mono;
            end
            else if (hit(addr, `LBL_ADDR_STATUS))
            begin
                next_st.rdata = status;
            end
            else
            begin
                next_st.rdata = 8'h00;
            end
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st.ctrl  <= `LBL_CTRL_RESET;
            st.mono  <= `LBL_MONO_RESET;
            st.rdata <= 8'h00;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_ctrl_write;
        wr && hit(addr, `LBL_ADDR_CTRL);
    endsequence

    sequence s_line_on;
        line_mode;
    endsequence

    sequence s_restart;
        wr && hit(addr, `LBL_ADDR_ACYC_RST);
    endsequence

    sequence s_cycle_step;
        auto_cycle && !cyc_restart && clamp_or_cycle_pin
            && !$past(clamp_or_cycle_pin);
    endsequence

    property p_ctrl_takes;
        s_ctrl_write |=> (line_mode == $past(wdata[`LBL_BIT_LINE]));
    endproperty

    a_mode_bit_write: assert property (p_ctrl_takes)
        else $error("Mode bit does not follow control write");

    a_mono_forced: assert property (
        s_line_on |-> mono_effective && channel_effective == `LBL_RED)
        else $error("Line mode does not force mono red");

    a_gain_paths_off: assert property (
        s_line_on |-> !green_gain_en && !blue_gain_en && red_gain_en)
        else $error("Green or blue gain active in line mode");

    a_pin_clamps: assert property (
        line_mode && !pin_select |-> clamp_active == clamp_or_cycle_pin)
        else $error("Pin does not clamp with select zero");

    a_cycle_steps: assert property (
        s_cycle_step |=> cyc_colour != $past(cyc_colour))
        else $error("Pin pulse did not step colour");

    a_pin_no_clamp: assert property (
        auto_cycle |-> clamp_active == int_clamp)
        else $error("Clamp not from internal bit in auto-cycle");

    a_override_mux: assert property (
        line_mode && ovr_en |-> input_mux_sel == colour_of(ovr_colour))
        else $error("Input mux ignores override colour");

    a_internal_colour: assert property (
        line_mode && !pin_select |->
            gain_offset_sel == colour_of(int_colour))
        else $error("Gain mux ignores internal colour");

    a_restart_red: assert property (
        s_restart |=> cyc_colour == `LBL_RED [*2] or
            (cyc_colour == `LBL_RED ##1 auto_cycle))
        else $error("Auto-cycle reset does not return to red");

    a_read_latency: assert property (
        rd && hit(addr, `LBL_ADDR_CTRL) && !wr |=> rdata == $past(st.ctrl))
        else $error("Control read data wrong");

    a_chan_normal: assert property (
        !line_mode && prog_chan != 2'h3 |->
            channel_effective == prog_chan)
        else $error("Channel pick not passed in normal mode");

    a_mono_normal: assert property (
        !line_mode |-> mono_effective == prog_mono)
        else $error("Mono forced outside line mode");

    a_gain_normal: assert property (
        !line_mode |-> green_gain_en && blue_gain_en)
        else $error("Gain path off outside line mode");

    a_clamp_normal: assert property (
        !line_mode |-> clamp_active == clamp_or_cycle_pin)
        else $error("Clamp ignores pin outside line mode");

    a_cycle_holds: assert property (
        !auto_cycle && !cyc_restart |=> cyc_colour == $past(cyc_colour))
        else $error("Colour moved without a step");

    a_ovr_ignored: assert property (
        !line_mode |-> input_mux_sel == gain_offset_sel)
        else $error("Override acts outside line mode");

    a_rdata_idle: assert property (
        !rd |=> rdata == 8'h00)
        else $error("Read data outside the read cycle");

endmodule : lbl_top

// ---- bench/lbl_pin_model.sv ----
/*
  Scanner controller side of the shared clamp or cycle pin.
  Assumes the bench calls its tasks from one process only.
*/
module lbl_pin_model (
    input  wire logic mclk,  // Bench clock
    output logic      pin    // Shared clamp or cycle pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pin rests low until the controller acts
    initial
    begin
        pin = 1'b0;
    end

    // One high cycle, then low so the next pulse is seen apart
    task automatic pulse();
        @(posedge mclk);
        pin <= 1'b1;
        @(posedge mclk);
        pin <= 1'b0;
    endtask : pulse

    // Steady level, used as a clamp request
    task automatic hold(input logic v);
        @(posedge mclk);
        pin <= v;
    endtask : hold
endmodule : lbl_pin_model

// ---- bench/line_by_line_colour_select_test.sv ----
/*
  Self-checking bench of the line-by-line colour select block.
  Assumes lbl_top and the pin model; registers reached by index.
*/
`include "lbl_defs.svh"

module line_by_line_colour_select_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk;
    logic       reset;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       pin;
    logic       mono_effective;
    logic [1:0] channel_effective;
    logic [1:0] input_mux_sel;
    logic [1:0] gain_offset_sel;
    logic       clamp_active;
    logic [2:0] gains;
    int         n_errors;
    int         checks_done;
    int         cyc;
    wire  [7:0] outs = {clamp_active, gain_offset_sel, input_mux_sel,
                        channel_effective, mono_effective};

    lbl_top u_lbl_top (
        .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .clamp_or_cycle_pin(pin),
        .mono_effective(mono_effective),
        .channel_effective(channel_effective),
        .input_mux_sel(input_mux_sel), .gain_offset_sel(gain_offset_sel),
        .clamp_active(clamp_active), .red_gain_en(gains[2]),
        .green_gain_en(gains[1]), .blue_gain_en(gains[0]));

    lbl_pin_model u_lbl_pin_model (.mclk(mclk), .pin(pin));

    // ---------------------------------------------------------------
    // Clock, reset and hang guard
    // ---------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Cuts the run short if a wait never ends
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    // ---------------------------------------------------------------
    // Register port master
    // ---------------------------------------------------------------
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wreg

    // Read data sampled in the one cycle it stands, then seen to drop
    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge mclk);
        #1;
        chk(rdata, 8'h00);
    endtask : rreg

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] v;
        rreg(`LBL_ADDR_CTRL, v);
        chk(v, 8'h00);
        chk(outs, 8'h00);
        chk({5'h0, gains}, 8'h07);
        $display("test reset done");
    endtask : t_reset

    // Line mode off: every other control bit must be ignored
    task automatic t_normal();
        logic [2:0] c;
        for (c = 0; c < 3; c++)
        begin
            wreg(`LBL_ADDR_MONO, {c[1:0], 6'h04});
            wreg(`LBL_ADDR_CTRL, 8'hfe);
            chk(outs, {1'b0, c[1:0], c[1:0], c[1:0], 1'b1});
            chk({5'h0, gains}, 8'h07);
        end
        u_lbl_pin_model.hold(1'b1);
        @(posedge mclk);
        #1;
        chk({7'h0, clamp_active}, 8'h01);
        u_lbl_pin_model.hold(1'b0);
        $display("test normal done");
    endtask : t_normal

    // Line mode with pin as clamp: internal colour drives both muxes
    task automatic t_line_int();
        logic [2:0] c;
        logic [1:0] e;
        wreg(`LBL_ADDR_MONO, 8'h80);
        for (c = 0; c < 4; c++)
        begin
            e = (c == 3) ? 2'h0 : c[1:0];
            wreg(`LBL_ADDR_CTRL, {2'h0, c[1:0], 4'h1});
            chk(outs, {1'b0, e, e, 3'h1});
            chk({5'h0, gains}, 8'h04);
        end
        u_lbl_pin_model.hold(1'b1);
        @(posedge mclk);
        #1;
        chk({7'h0, clamp_active}, 8'h01);
        u_lbl_pin_model.hold(1'b0);
        $display("test line internal done");
    endtask : t_line_int

    // Override moves the input mux only
    task automatic t_override();
        logic [2:0] f;
        logic [1:0] e;
        for (f = 0; f < 4; f++)
        begin
            e = (f == 3) ? 2'h0 : f[1:0];
            wreg(`LBL_ADDR_CTRL, {f[1:0], 2'h1, 4'h5});
            chk(outs, {1'b0, 2'h1, e, 3'h1});
        end
        $display("test override done");
    endtask : t_override

    // Auto-cycle steps, clamp from bit 3, restart and ignored steps
    task automatic t_cycle();
        logic [2:0] k;
        logic [1:0] e;
        wreg(`LBL_ADDR_CTRL, 8'h03);
        wreg(`LBL_ADDR_ACYC_RST, 8'h00);
        chk(outs, 8'h01);
        for (k = 1; k < 4; k++)
        begin
            e = (k == 3) ? 2'h0 : k[1:0];
            u_lbl_pin_model.pulse();
            #1;
            chk(outs, {1'b0, e, e, 3'h1});
        end
        u_lbl_pin_model.hold(1'b1);
        @(posedge mclk);
        #1;
        chk(outs, {1'b0, 2'h1, 2'h1, 3'h1});
        wreg(`LBL_ADDR_CTRL, 8'h0b);
        chk(outs, {1'b1, 2'h1, 2'h1, 3'h1});
        u_lbl_pin_model.hold(1'b0);
        wreg(`LBL_ADDR_ACYC_RST, 8'h5a);
        chk(outs, 8'h81);
        wreg(`LBL_ADDR_CTRL, 8'h00);
        u_lbl_pin_model.pulse();
        wreg(`LBL_ADDR_CTRL, 8'h03);
        chk(outs, 8'h01);
        $display("test cycle done");
    endtask : t_cycle

    // Read back, unmapped index and read-only status
    task automatic t_regs();
        logic [7:0] v;
        wreg(`LBL_ADDR_CTRL, 8'ha5);
        wreg(4'hf, 8'hff);
        wreg(`LBL_ADDR_STATUS, 8'hff);
        rreg(`LBL_ADDR_CTRL, v);
        chk(v, 8'ha5);
        rreg(4'hf, v);
        chk(v, 8'h00);
        rreg(`LBL_ADDR_STATUS, v);
        chk(v, 8'h51);
        rreg(`LBL_ADDR_MONO, v);
        chk(v, 8'h80);
        $display("test registers done");
    endtask : t_regs

    // Reset in mid-run clears registers and the colour counter
    task automatic t_midreset();
        logic [7:0] v;
        wreg(`LBL_ADDR_CTRL, 8'h03);
        u_lbl_pin_model.pulse();
        #1;
        chk(outs, {1'b0, 2'h1, 2'h1, 3'h1});
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk(outs, 8'h00);
        chk({5'h0, gains}, 8'h07);
        rreg(`LBL_ADDR_CTRL, v);
        chk(v, 8'h00);
        wreg(`LBL_ADDR_CTRL, 8'h03);
        chk(outs, 8'h01);
        $display("test mid-run reset done");
    endtask : t_midreset

    // Main sequence
    initial
    begin
        reset       = 1'b1;
        addr        = 4'h0;
        wdata       = 8'h00;
        wr          = 1'b0;
        rd          = 1'b0;
        n_errors    = 0;
        checks_done = 0;
        cyc         = 0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_normal();
        t_line_int();
        t_override();
        t_cycle();
        t_regs();
        t_midreset();
        close_out();
    end
endmodule : line_by_line_colour_select_test
